// file: hw/tps_switch.sv
`timescale 1ns/1ns
`default_nettype none
module tps_switch (
	input  wire logic                  clk,
	input  wire logic                  rst_b,
	input  wire logic                  frame_pulse_in_b,
	input  wire logic                  master_clock_in,
	input  wire logic                  gen_frame_pulse_b,
	input  wire logic                  mode_wr,
	input  wire logic                  mode_wr_local,
	input  wire logic                  mode_wr_bp,
	input  wire logic                  rate_wr,
	input  wire logic                  rate_wr_dir,
	input  wire logic                  rate_wr_port,
	input  wire logic [4:0]            rate_wr_idx,
	input  wire logic [1:0]            rate_wr_val,
	input  wire logic                  in_valid,
	input  wire tps_pkg::tps_in_s      in_word,
	input  wire logic                  req_valid,
	input  wire tps_pkg::tps_req_s     req_word,
	output logic                       req_ready,
	output logic                       out_valid,
	output tps_pkg::tps_out_s          out_word,
	input  wire logic                  out_ready,
	output logic                       local_fast_mode_bit,
	output logic                       backplane_fast_mode_bit,
	output logic                       in_locked,
	output logic                       out_locked,
	output logic [10:0]                frame_clk_count,
	output tps_pkg::tps_rate_e [31:0]  bp_in_rate,
	output tps_pkg::tps_rate_e [31:0]  bp_out_rate,
	output tps_pkg::tps_rate_e [15:0]  lc_in_rate,
	output tps_pkg::tps_rate_e [15:0]  lc_out_rate
);
	////////////////////////////////////////////////////////////////
	logic [31:0][1:0] backplane_input_rate_reg;
	logic [31:0][1:0] backplane_output_rate_reg;
	logic [15:0][1:0] local_input_rate_reg;
	logic [15:0][1:0] local_output_rate_reg;
	logic             lc_fast_r;
	logic             bp_fast_r;

	function automatic tps_pkg::tps_rate_e eff(input logic fast, input logic [4:0] s,
		input logic [4:0] lim, input logic [1:0] f);
		if (fast)
			return (s < lim) ? tps_pkg::R32 : tps_pkg::UNUSED;
		return tps_pkg::tps_rate_e'({1'b0, f});
	endfunction

	function automatic logic chan_ok(input tps_pkg::tps_rate_e r, input logic [8:0] c);
		if (r == tps_pkg::UNUSED)
			return 1'b0;
		return (c >> (tps_pkg::CH_SLOW_SHIFT + int'(r))) == 9'h000;
	endfunction

	// Fast mode packs the stream number one bit tighter to keep 512 channels
	function automatic logic [12:0] mem_addr(input logic port, input logic fast,
		input logic [4:0] s, input logic [8:0] c);
		if (port == tps_pkg::PORT_BP)
			return fast ? {s[3:0], c} : {s, c[7:0]};
		return fast ? {1'b0, s[2:0], c} : {1'b0, s[3:0], c[7:0]};
	endfunction

	// Each port sees only its own mode bit and rate fields
	function automatic tps_pkg::tps_rate_e rate_of(input logic port, input logic dir,
		input logic [4:0] s);
		if (port == tps_pkg::PORT_BP)
			return eff(bp_fast_r, s, tps_pkg::BP_FAST_LIM,
				dir == tps_pkg::DIR_IN ? backplane_input_rate_reg[s] : backplane_output_rate_reg[s]);
		// Local port stops at stream 15; higher numbers must not alias onto 0-15
		if (s >= 5'(tps_pkg::LC_STREAMS))
			return tps_pkg::UNUSED;
		return eff(lc_fast_r, s, tps_pkg::LC_FAST_LIM,
			dir == tps_pkg::DIR_IN ? local_input_rate_reg[s[3:0]] : local_output_rate_reg[s[3:0]]);
	endfunction

	////////////////////////////////////////////////////////////////
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			lc_fast_r <= tps_pkg::MODE_RST;
			bp_fast_r <= tps_pkg::MODE_RST;
		end else if (mode_wr) begin
			lc_fast_r <= mode_wr_local;
			bp_fast_r <= mode_wr_bp;
		end
	end

	// Rate fields are kept while a port is fast, so leaving fast mode restores them
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			backplane_input_rate_reg  <= {32{tps_pkg::RATE_RST}};
			backplane_output_rate_reg <= {32{tps_pkg::RATE_RST}};
			local_input_rate_reg      <= {16{tps_pkg::RATE_RST}};
			local_output_rate_reg     <= {16{tps_pkg::RATE_RST}};
		end else if (rate_wr) begin
			if (rate_wr_port == tps_pkg::PORT_BP && rate_wr_dir == tps_pkg::DIR_IN)
				backplane_input_rate_reg[rate_wr_idx] <= rate_wr_val;
			if (rate_wr_port == tps_pkg::PORT_BP && rate_wr_dir != tps_pkg::DIR_IN)
				backplane_output_rate_reg[rate_wr_idx] <= rate_wr_val;
			if (rate_wr_port == tps_pkg::PORT_LC && rate_wr_dir == tps_pkg::DIR_IN)
				local_input_rate_reg[rate_wr_idx[3:0]] <= rate_wr_val;
			if (rate_wr_port == tps_pkg::PORT_LC && rate_wr_dir != tps_pkg::DIR_IN)
				local_output_rate_reg[rate_wr_idx[3:0]] <= rate_wr_val;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			bp_in_rate  <= '{default: tps_pkg::R2};
			bp_out_rate <= '{default: tps_pkg::R2};
			lc_in_rate  <= '{default: tps_pkg::R2};
			lc_out_rate <= '{default: tps_pkg::R2};
		end else begin
			for (int i = 0; i < tps_pkg::BP_STREAMS; i++) begin
				bp_in_rate[i]  <= rate_of(tps_pkg::PORT_BP, 1'b0, 5'(i));
				bp_out_rate[i] <= rate_of(tps_pkg::PORT_BP, 1'b1, 5'(i));
			end
			for (int i = 0; i < tps_pkg::LC_STREAMS; i++) begin
				lc_in_rate[i]  <= rate_of(tps_pkg::PORT_LC, 1'b0, 5'(i));
				lc_out_rate[i] <= rate_of(tps_pkg::PORT_LC, 1'b1, 5'(i));
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			local_fast_mode_bit     <= tps_pkg::MODE_RST;
			backplane_fast_mode_bit <= tps_pkg::MODE_RST;
		end else begin
			local_fast_mode_bit     <= lc_fast_r;
			backplane_fast_mode_bit <= bp_fast_r;
		end
	end

	////////////////////////////////////////////////////////////////
	// Pin timing: two flops, then a history flop for edge detection
	logic [2:0] sync1_r;
	logic [2:0] sync2_r;
	logic [2:0] hist_r;
	logic       fp_fall;
	logic       gfp_fall;
	logic       mclk_fall;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			// Clock pin idles low, frame pins high: no false edge after reset
			sync1_r <= 3'h5;
			sync2_r <= 3'h5;
			hist_r  <= 3'h5;
		end else begin
			sync1_r <= {gen_frame_pulse_b, master_clock_in, frame_pulse_in_b};
			sync2_r <= sync1_r;
			hist_r  <= sync2_r;
		end
	end

	assign fp_fall   = hist_r[0] && !sync2_r[0];
	assign mclk_fall = hist_r[1] && !sync2_r[1];
	assign gfp_fall  = hist_r[2] && !sync2_r[2];

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			in_locked       <= 1'b0;
			frame_clk_count <= 11'h000;
		end else begin
			if (fp_fall)
				in_locked <= 1'b1;
			if (fp_fall)
				frame_clk_count <= 11'h000;
			else if (mclk_fall)
				frame_clk_count <= frame_clk_count + 11'h001;
		end
	end

	////////////////////////////////////////////////////////////////
	logic [7:0] bp_mem [tps_pkg::BP_MEM_WORDS];
	logic [7:0] lc_mem [tps_pkg::LC_MEM_WORDS];
	logic       in_take;
	logic [12:0] in_addr;

	// Unused fast-mode streams are discarded, whatever level the far end holds
	// A process, not an assign, so rate and mode changes re-evaluate the functions
	always_comb begin
		in_take = in_valid && in_locked &&
			chan_ok(rate_of(in_word.port, tps_pkg::DIR_IN, in_word.stream), in_word.chan);
		in_addr = mem_addr(in_word.port, in_word.port ? bp_fast_r : lc_fast_r,
			in_word.stream, in_word.chan);
	end

	always_ff @(posedge clk) begin
		if (in_take && in_word.port == tps_pkg::PORT_BP)
			bp_mem[in_addr] <= in_word.data;
		if (in_take && in_word.port == tps_pkg::PORT_LC)
			lc_mem[in_addr[11:0]] <= in_word.data;
	end

	////////////////////////////////////////////////////////////////
	tps_pkg::tps_cm_s  cm;
	tps_pkg::tps_out_s item;
	tps_pkg::tps_out_s skid_r;
	logic              skid_v_r;
	logic              push;
	logic              dst_ok;
	logic              src_ok;
	logic [12:0]       src_addr;
	logic [7:0]        bp_rd;
	logic [7:0]        lc_rd;

	assign cm       = req_word.cm;
	assign push     = req_valid && req_ready;
	// Source select uses the port codes: low local, high backplane
	always_comb begin
		dst_ok   = chan_ok(rate_of(req_word.port, 1'b1, req_word.stream), req_word.chan);
		src_ok   = chan_ok(rate_of(cm.src_sel, tps_pkg::DIR_IN, cm.src_stream), cm.src_chan);
		src_addr = mem_addr(cm.src_sel, cm.src_sel ? bp_fast_r : lc_fast_r,
			cm.src_stream, cm.src_chan);
	end
	assign bp_rd    = bp_mem[src_addr];
	assign lc_rd    = lc_mem[src_addr[11:0]];

	// src_sel low means local data memory; same meaning on both output ports
	always_comb begin
		item        = '0;
		item.port   = req_word.port;
		item.stream = req_word.stream;
		item.chan   = req_word.chan;
		item.drive  = cm.enable && dst_ok;
		if (cm.msg_mode)
			item.data = cm.msg;
		else if (!src_ok)
			item.data = tps_pkg::IDLE_BYTE;
		else if (cm.src_sel == tps_pkg::SRC_LC)
			item.data = lc_rd;
		else
			item.data = bp_rd;
	end

	// Two-entry buffer: output register plus skid, so a stall loses nothing
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			out_valid <= 1'b0;
			out_word  <= '0;
			skid_v_r  <= 1'b0;
			skid_r    <= '0;
		end else if (!out_valid || out_ready) begin
			out_valid <= skid_v_r || push;
			out_word  <= skid_v_r ? skid_r : item;
			skid_v_r  <= 1'b0;
		end else if (push) begin
			skid_r   <= item;
			skid_v_r <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			out_locked <= 1'b0;
			req_ready  <= 1'b0;
		end else begin
			if (gfp_fall)
				out_locked <= 1'b1;
			req_ready <= (out_locked || gfp_fall) &&
				!(out_valid && !out_ready && (skid_v_r || push));
		end
	end

	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	lc_fast_map_a: assert property (lc_fast_r && !mode_wr |=> lc_in_rate[0] == tps_pkg::R32 && lc_out_rate[8] == tps_pkg::UNUSED)
		else $error("local fast mode stream map wrong");
	bp_fast_map_a: assert property (bp_fast_r && !mode_wr |=> bp_in_rate[15] == tps_pkg::R32 && bp_out_rate[16] == tps_pkg::UNUSED)
		else $error("backplane fast mode stream map wrong");
	lc_slow_rate_a: assert property (!lc_fast_r && !mode_wr |=> lc_in_rate[3] == tps_pkg::tps_rate_e'({1'b0, $past(local_input_rate_reg[3])}))
		else $error("local slow rate not from its field");
	bp_slow_rate_a: assert property (!bp_fast_r && !mode_wr |=> bp_out_rate[31] == tps_pkg::tps_rate_e'({1'b0, $past(backplane_output_rate_reg[31])}))
		else $error("backplane slow rate not from its field");
	rate_write_a: assert property (rate_wr && rate_wr_port == tps_pkg::PORT_LC && rate_wr_dir == tps_pkg::DIR_IN |=> ##1 !lc_fast_r && !$past(mode_wr) |-> lc_in_rate[$past(rate_wr_idx[3:0], 2)] == tps_pkg::tps_rate_e'({1'b0, $past(rate_wr_val, 2)}))
		else $error("local input rate write not seen");
	port_indep_a: assert property ($stable(lc_fast_r) && $stable(local_output_rate_reg) |=> $stable(lc_out_rate))
		else $error("local rate moved with other port");
	mode_bits_a: assert property (mode_wr |=> lc_fast_r == $past(mode_wr_local) && bp_fast_r == $past(mode_wr_bp) ##1 local_fast_mode_bit == $past(mode_wr_local, 2))
		else $error("mode bit write not applied");
	hiz_ctrl_a: assert property (push && !out_valid && !cm.enable |=> out_valid && !out_word.drive)
		else $error("disabled channel was driven");
	msg_path_a: assert property (push && !out_valid && cm.msg_mode |=> out_word.data == $past(cm.msg))
		else $error("message byte not sent");
	src_path_a: assert property (push && !out_valid && !cm.msg_mode && src_ok |=> out_word.data == $past(cm.src_sel == tps_pkg::SRC_LC ? lc_rd : bp_rd))
		else $error("wrong data memory used");
	stall_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_word))
		else $error("stalled word changed");
	in_align_a: assert property (!in_locked |-> !in_take)
		else $error("input taken before frame");
	out_align_a: assert property (!out_locked && !gfp_fall |=> !req_ready)
		else $error("request taken before output frame");
endmodule // tps_switch
`default_nettype wire

// file: hw/tps_pkg.sv
package tps_pkg;
	localparam int BP_STREAMS = 32;
	localparam int LC_STREAMS = 16;
	localparam logic [4:0] BP_FAST_LIM = 5'h10;
	localparam logic [4:0] LC_FAST_LIM = 5'h08;
	localparam int CH_SLOW_SHIFT = 5;
	localparam logic [1:0] RATE_RST = 2'h0;
	localparam logic MODE_RST = 1'b0;
	localparam logic PORT_LC = 1'b0;
	localparam logic PORT_BP = 1'b1;
	localparam logic DIR_IN = 1'b0;
	localparam logic SRC_LC = 1'b0;
	localparam logic [7:0] IDLE_BYTE = 8'hff;
	localparam int BP_MEM_WORDS = 8192;
	localparam int LC_MEM_WORDS = 4096;
	localparam int CLK_CNT_W = 11;

	typedef enum logic [2:0] {
		R2 = 3'h0, R4 = 3'h1, R8 = 3'h2, R16 = 3'h3, R32 = 3'h4, UNUSED = 3'h7
	} tps_rate_e;

	typedef struct packed {
		logic       port;
		logic [4:0] stream;
		logic [8:0] chan;
		logic [7:0] data;
	} tps_in_s;

	typedef struct packed {
		logic       msg_mode;
		logic       enable;
		logic       src_sel;
		logic [4:0] src_stream;
		logic [8:0] src_chan;
		logic [7:0] msg;
	} tps_cm_s;

	typedef struct packed {
		logic       port;
		logic [4:0] stream;
		logic [8:0] chan;
		tps_cm_s    cm;
	} tps_req_s;

	typedef struct packed {
		logic       port;
		logic [4:0] stream;
		logic [8:0] chan;
		logic [7:0] data;
		logic       drive;
	} tps_out_s;
endpackage

// file: testbench/tps_far_end.sv
`timescale 1ns/1ns
`default_nettype none
module tps_far_end (
	input  wire logic clk,
	input  wire logic stall,
	output logic      frame_pulse_in_b,
	output logic      master_clock_in,
	output logic      gen_frame_pulse_b,
	output logic      out_ready
);
	int cnt  = 15000;
	int seed = 75818;
	initial begin
		frame_pulse_in_b  = 1'b1;
		master_clock_in   = 1'b0;
		gen_frame_pulse_b = 1'b1;
		out_ready         = 1'b1;
	end
	// Real 8 kHz spacing; the count starts late so the first frame comes early
	always @(posedge clk) begin
		cnt               <= cnt + 1;
		master_clock_in   <= #1 cnt[3];
		frame_pulse_in_b  <= #1 (cnt % 15625) > 1;
		gen_frame_pulse_b <= #1 (cnt % 15625) < 40 || (cnt % 15625) > 41;
		// Random back-pressure, never kinder than a real sink
		out_ready         <= #1 !stall && ($random(seed) % 4 != 0);
	end
endmodule // tps_far_end
`default_nettype wire

// file: testbench/tps_switch_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tps_switch_tb_top;
	logic                      clk = 1'b0, rst_b = 1'b0, stall = 1'b0;
	logic                      fp_b, mclk, gfp_b, rdy, req_ready, out_valid, lfm, bfm, in_lk, out_lk;
	logic                      mode_wr = 1'b0, m_lc = 1'b0, m_bp = 1'b0, in_valid = 1'b0, req_valid = 1'b0;
	logic                      rate_wr = 1'b0, r_dir = 1'b0, r_port = 1'b0;
	logic [4:0]                r_idx = 5'h00;
	logic [1:0]                r_val = 2'h0;
	logic [10:0]               fcc;
	tps_pkg::tps_in_s          in_word = '0;
	tps_pkg::tps_req_s         req_word = '0, r;
	tps_pkg::tps_out_s         out_word;
	tps_pkg::tps_out_s         got [$], exp_q [$];
	tps_pkg::tps_rate_e [31:0] bpi, bpo;
	tps_pkg::tps_rate_e [15:0] lci, lco;
	logic [1:0]                fld [2][2][32];
	logic [7:0]                mem [2][32][32];
	logic                      wp [8];
	logic [4:0]                ws [8], wc [8];
	logic [31:0]               v;
	int                        failures = 0, checks = 0, seed = 75818, n, j;

	always #4 clk = ~clk;
	always @(posedge clk) if (out_valid === 1'b1 && rdy === 1'b1) got.push_back(out_word);

	tps_far_end i_tps_far_end (.clk(clk), .stall(stall), .frame_pulse_in_b(fp_b), .master_clock_in(mclk),
		.gen_frame_pulse_b(gfp_b), .out_ready(rdy));
	tps_switch i_tps_switch (.clk(clk), .rst_b(rst_b), .frame_pulse_in_b(fp_b), .master_clock_in(mclk),
		.gen_frame_pulse_b(gfp_b), .mode_wr(mode_wr), .mode_wr_local(m_lc), .mode_wr_bp(m_bp),
		.rate_wr(rate_wr), .rate_wr_dir(r_dir), .rate_wr_port(r_port), .rate_wr_idx(r_idx),
		.rate_wr_val(r_val), .in_valid(in_valid), .in_word(in_word), .req_valid(req_valid),
		.req_word(req_word), .req_ready(req_ready), .out_valid(out_valid), .out_word(out_word),
		.out_ready(rdy), .local_fast_mode_bit(lfm), .backplane_fast_mode_bit(bfm), .in_locked(in_lk),
		.out_locked(out_lk), .frame_clk_count(fcc), .bp_in_rate(bpi), .bp_out_rate(bpo),
		.lc_in_rate(lci), .lc_out_rate(lco));

	////////////////////////////////////////////////////////////////////////
	task automatic wrap_up;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	function automatic tps_pkg::tps_rate_e exp_rate(input logic fast, input int lim, input int i,
		input logic [1:0] f);
		if (!fast) return tps_pkg::tps_rate_e'({1'b0, f});
		return (i < lim) ? tps_pkg::R32 : tps_pkg::UNUSED;
	endfunction

	task automatic check_rates(input logic f_lc, input logic f_bp);
		for (int i = 0; i < 32; i++) begin
			check(bpi[i], exp_rate(f_bp, 16, i, fld[1][0][i]));
			check(bpo[i], exp_rate(f_bp, 16, i, fld[1][1][i]));
			if (i < 16) check(lci[i], exp_rate(f_lc, 8, i, fld[0][0][i]));
			if (i < 16) check(lco[i], exp_rate(f_lc, 8, i, fld[0][1][i]));
		end
		check(lfm, f_lc);
		check(bfm, f_bp);
	endtask

	// Strobe stays up between back-to-back calls; the caller lowers it
	task automatic wr_rate(input logic p, input logic d, input logic [4:0] i, input logic [1:0] val);
		r_port = p;
		r_dir = d;
		r_idx = i;
		r_val = val;
		rate_wr = 1'b1;
		fld[p][d][p ? i : {1'b0, i[3:0]}] = val;
		@(posedge clk);
		#1;
	endtask

	task automatic set_mode(input logic l, input logic b);
		m_lc = l;
		m_bp = b;
		mode_wr = 1'b1;
		@(posedge clk);
		#1 mode_wr = 1'b0;
		repeat (2) @(posedge clk);
		#1 check_rates(l, b);
	endtask

	function automatic tps_pkg::tps_out_s exp_out(input tps_pkg::tps_req_s q, input logic dl);
		tps_pkg::tps_out_s o;
		o = '{q.port, q.stream, q.chan, 8'h00, q.cm.enable & dl};
		if (q.cm.msg_mode) o.data = q.cm.msg;
		else if (q.cm.src_sel == tps_pkg::SRC_LC && q.cm.src_stream > 5'h0f) o.data = tps_pkg::IDLE_BYTE;
		else o.data = mem[q.cm.src_sel][q.cm.src_stream][q.cm.src_chan[4:0]];
		return o;
	endfunction

	task automatic push(input tps_pkg::tps_req_s q, input logic dl);
		int k;
		k = 0;
		exp_q.push_back(exp_out(q, dl));
		req_word = q;
		req_valid = 1'b1;
		do begin
			@(posedge clk);
			k++;
		end while (req_ready !== 1'b1 && k < 100);
		#1;
		if (k >= 100) failures++;
	endtask

	task automatic drain;
		n = 0;
		while (got.size() < exp_q.size() && n < 200) begin
			@(posedge clk);
			n++;
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		#300000 failures++;
		wrap_up();
	end

	initial begin
		foreach (fld[a, b, c]) fld[a][b][c] = tps_pkg::RATE_RST;
		repeat (2) @(posedge clk);
		#1 rst_b = 1'b1;
		check_rates(1'b0, 1'b0);
		for (int k = 0; k < 40; k++) begin
			v = $random(seed);
			wr_rate(v[0], v[1], v[6:2], v[8:7]);
		end
		wr_rate(1'b1, 1'b1, 5'h1f, 2'h3);
		wr_rate(1'b0, 1'b0, 5'h0f, 2'h3);
		wr_rate(1'b0, 1'b1, 5'h03, 2'h0);
		rate_wr = 1'b0;
		repeat (2) @(posedge clk);
		#1 check_rates(1'b0, 1'b0);
		set_mode(1'b1, 1'b0);
		set_mode(1'b0, 1'b1);
		set_mode(1'b1, 1'b1);
		set_mode(1'b0, 1'b0);
		n = 0;
		while (!(in_lk === 1'b1 && out_lk === 1'b1) && n < 20000) begin
			@(posedge clk);
			n++;
		end
		#1 check(in_lk, 1'b1);
		check(out_lk, 1'b1);
		check(fcc > 11'h000 && fcc < 11'h010, 1'b1);
		for (int k = 0; k < 8; k++) begin
			v = $random(seed);
			wp[k] = v[0];
			ws[k] = v[0] ? v[5:1] : {1'b0, v[4:1]};
			wc[k] = v[10:6];
			mem[wp[k]][ws[k]][wc[k]] = v[18:11];
			in_word = '{wp[k], ws[k], {4'h0, wc[k]}, v[18:11]};
			in_valid = 1'b1;
			@(posedge clk);
			#1;
		end
		in_valid = 1'b0;
		for (int k = 0; k < 12; k++) begin
			j = $unsigned($random(seed)) % 8;
			v = $random(seed);
			r = '{v[0], v[0] ? v[5:1] : {1'b0, v[4:1]}, {4'h0, v[10:6]},
				'{v[11], v[12], wp[j], ws[j], {4'h0, wc[j]}, v[20:13]}};
			push(r, 1'b1);
		end
		push('{1'b1, 5'h02, 9'h001, '{1'b0, 1'b1, 1'b0, 5'h14, 9'h000, 8'h00}}, 1'b1);
		push('{1'b0, 5'h03, 9'h028, '{1'b1, 1'b1, 1'b0, 5'h00, 9'h000, 8'h5a}}, 1'b0);
		req_valid = 1'b0;
		drain();
		#1 stall = 1'b1;
		repeat (3) @(posedge clk);
		#1 push('{1'b1, 5'h01, 9'h002, '{1'b1, 1'b1, 1'b1, 5'h00, 9'h000, 8'h3c}}, 1'b1);
		push('{1'b0, 5'h01, 9'h002, '{1'b1, 1'b0, 1'b1, 5'h00, 9'h000, 8'hc3}}, 1'b1);
		fork
			push('{1'b1, 5'h1f, 9'h01f, '{1'b1, 1'b1, 1'b0, 5'h00, 9'h000, 8'h99}}, 1'b1);
			begin
				repeat (4) begin
					@(posedge clk);
					check(req_ready, 1'b0);
				end
				#1 stall = 1'b0;
			end
		join
		req_valid = 1'b0;
		drain();
		check(got.size(), exp_q.size());
		foreach (exp_q[k]) if (k < got.size()) check(got[k], exp_q[k]);
		wrap_up();
	end
endmodule // tps_switch_tb_top
`default_nettype wire
